// >>> dlt_pkg.sv
// Purpose: constants and types for the load and reset command register
// Assumes: 16-bit register words, 5-bit register addresses
// Notes: shared by the command register block and its users
package dlt_pkg;
    localparam int DLT_DATA_W = 16;
    localparam int DLT_ADDR_W = 5;
    localparam int DLT_PAIRS = 8;
    localparam logic [4:0] DLT_CMD_OFFSET = 5'h05;
    localparam logic [15:0] DLT_CMD_RESET = 16'h0000;
    localparam int DLT_LOAD_LSB = 8;
    localparam int DLT_KEY_MSB = 3;
    localparam logic [3:0] DLT_RESET_KEY = 4'hA;
    localparam logic [3:0] DLT_KEY_IDLE = 4'h0;
    localparam logic [7:0] DLT_PAIRS_NONE = 8'h00;
    // number of cycles the device-wide reset pulse is held
    localparam logic [3:0] DLT_RST_PULSE = 4'h4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } dlt_req_t;

    typedef enum logic [2:0] {
        DLT_IDLE = 3'b001,
        DLT_LOAD = 3'b010,
        DLT_SRST = 3'b100
    } dlt_state_t;
endpackage

// >>> dlt_cmd_reg.sv
// Purpose: load trigger and software reset command register
// Assumes: register access decoded by the serial front end into one-cycle strobes
// Notes: load and reset requests clear themselves once carried out
//   the device-wide reset pulse lasts DLT_RST_PULSE cycles from the key write
//   a key write also drops every pending pair load, since the reset wins
//   channels not in synchronous mode count as done at once, so a pair
//   with no synchronous channel clears on the cycle after its request
//   reads of the command offset answer with zero, as all fields are write-only
//   writes to any other offset are ignored and get no answer
//
// Functional notes
// R01: decode at offset 5h, reset 0000h
// R02: bits 15 to 8 request pair loads
// R03: load copies buffer to active, synchronous channels
// R04: zero does nothing, one starts transfer
// R05: load bit clears itself after transfer
// R06: key Ah in bits 3:0 resets device
// R07: soft reset equals power-on default state
// R08: key field self-clears; bits 7:4 read zero
// R09: other key values have no effect
`timescale 1ns/1ps
module dlt_cmd_reg
    import dlt_pkg::*;
#(
    parameter int PAIRS = DLT_PAIRS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire dlt_req_t req,
    input wire logic [2*PAIRS-1:0] sync_mode,
    input wire logic [2*PAIRS-1:0] load_done,
    output logic [DLT_DATA_W-1:0] rdata,
    output logic rvalid,
    output logic [2*PAIRS-1:0] load_strobe,
    output logic [PAIRS-1:0] pending,
    output logic device_reset
);
    dlt_state_t state;
    logic [PAIRS-1:0] pair_busy;
    logic [3:0] rst_count;
    logic hit_wr;
    logic key_hit;
    logic [PAIRS-1:0] new_req;

    // register decode
    assign hit_wr = req.wr && (req.addr == DLT_CMD_OFFSET); // R01
    assign key_hit = hit_wr && (req.wdata[DLT_KEY_MSB:0] == DLT_RESET_KEY); // R06 R09
    assign new_req = hit_wr ? req.wdata[DLT_LOAD_LSB +: PAIRS] : '0; // R02 R04

    // overall state: soft reset overrides everything else
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= DLT_IDLE;
            rst_count <= DLT_KEY_IDLE;
        end else begin
            case (state)
                DLT_IDLE, DLT_LOAD: begin
                    if (key_hit) begin
                        state <= DLT_SRST; // R06
                        rst_count <= DLT_RST_PULSE;
                    end else if (new_req != '0 || pair_busy != '0) begin
                        state <= DLT_LOAD;
                    end else begin
                        state <= DLT_IDLE;
                    end
                end
                DLT_SRST: begin
                    if (rst_count == 4'h1) begin
                        state <= DLT_IDLE; // R08
                    end
                    rst_count <= rst_count - 4'h1;
                end
                default: begin
                    state <= DLT_IDLE;
                end
            endcase
        end
    end

    // per-pair request bits, set by host, cleared when both channels report done or are not synchronous
    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : g_pair
            logic [1:0] done_pair;
            assign done_pair = load_done[2*g +: 2] | ~sync_mode[2*g +: 2];
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    pair_busy[g] <= 1'b0;
                    load_strobe[2*g +: 2] <= 2'b00;
                end else if (state == DLT_SRST || key_hit) begin
                    pair_busy[g] <= 1'b0; // R07
                    load_strobe[2*g +: 2] <= 2'b00;
                end else begin
                    // only synchronous channels are moved
                    load_strobe[2*g +: 2] <= new_req[g] ? sync_mode[2*g +: 2] : 2'b00; // R03
                    if (new_req[g]) begin
                        pair_busy[g] <= 1'b1; // R04
                    end else if (pair_busy[g] && done_pair == 2'b11) begin
                        pair_busy[g] <= 1'b0; // R05
                    end
                end
            end
        end
    endgenerate

    // outputs registered; command register is write-only so reads give zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= DLT_CMD_RESET; // R01
            rvalid <= 1'b0;
            pending <= DLT_PAIRS_NONE;
            device_reset <= 1'b0;
        end else begin
            rvalid <= req.rd && (req.addr == DLT_CMD_OFFSET);
            rdata <= DLT_CMD_RESET; // R08
            pending <= pair_busy;
            device_reset <= key_hit || (state == DLT_SRST && rst_count != 4'h1); // R07
        end
    end

    chk_key_resets: assert property (@(posedge sys_clk) disable iff (rst)
        key_hit |=> device_reset [*4] ##1 !device_reset) // R06
        else $error("reset pulse wrong");
    chk_bad_key: assert property (@(posedge sys_clk) disable iff (rst)
        (state == DLT_IDLE && !key_hit) |=> !device_reset) // R09
        else $error("reset without key");
    chk_strobe_sync: assert property (@(posedge sys_clk) disable iff (rst)
        (load_strobe & ~$past(sync_mode)) == '0) // R03
        else $error("async channel loaded");
    chk_zero_noop: assert property (@(posedge sys_clk) disable iff (rst)
        (hit_wr && !key_hit && new_req == '0 && pair_busy == '0 && state != DLT_SRST)
        |=> load_strobe == '0 && pair_busy == '0) // R04
        else $error("zero write acted");
    chk_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
        rvalid |-> rdata == DLT_CMD_RESET) // R08
        else $error("read not zero");
    chk_req_sets: assert property (@(posedge sys_clk) disable iff (rst)
        (new_req[0] && !key_hit && state != DLT_SRST) |=> pair_busy[0]) // R02
        else $error("request lost");
    chk_self_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (pair_busy[0] && !new_req[0] && (load_done[1:0] | ~sync_mode[1:0]) == 2'b11)
        |=> !pair_busy[0]) // R05
        else $error("request not cleared");
    chk_reset_clears: assert property (@(posedge sys_clk) disable iff (rst)
        state == DLT_SRST |=> pair_busy == '0 && load_strobe == '0) // R07
        else $error("state survived reset");
    chk_offset_only: assert property (@(posedge sys_clk) disable iff (rst)
        (req.wr && req.addr != DLT_CMD_OFFSET && pair_busy == '0 && state == DLT_IDLE)
        |=> load_strobe == '0) // R01
        else $error("wrong offset decoded");

    // a read of the command offset is answered on the next cycle
    chk_read_answer: assert property (@(posedge sys_clk) disable iff (rst) // R01
        (req.rd && req.addr == DLT_CMD_OFFSET) |=> rvalid)
        else $error("read not answered");

    // no answer without a read of the command offset
    chk_read_other: assert property (@(posedge sys_clk) disable iff (rst) // R01
        !(req.rd && req.addr == DLT_CMD_OFFSET) |=> !rvalid)
        else $error("answer without read");

    // read data stays zero between answers too
    chk_rdata_zero: assert property (@(posedge sys_clk) disable iff (rst) // R08
        !rvalid |-> rdata == DLT_CMD_RESET)
        else $error("read data not zero");

    // pending mirrors the busy bits one cycle late
    chk_pending_copy: assert property (@(posedge sys_clk) disable iff (rst) // R05
        pending == $past(pair_busy))
        else $error("pending out of step");

    // the state code is always one of the three one-hot codes
    chk_state_onehot: assert property (@(posedge sys_clk) disable iff (rst) // R07
        $onehot(state))
        else $error("state code broken");

    // the soft reset always ends and returns to idle
    chk_srst_ends: assert property (@(posedge sys_clk) disable iff (rst) // R08
        state == DLT_SRST |-> ##[1:4] state == DLT_IDLE)
        else $error("soft reset stuck");

    // counter stays inside its pulse length while resetting
    chk_count_range: assert property (@(posedge sys_clk) disable iff (rst) // R08
        state == DLT_SRST |-> rst_count != 4'h0 && rst_count <= DLT_RST_PULSE)
        else $error("reset count out of range");

    // a strobe needs a request for that pair one cycle before
    chk_strobe_cause: assert property (@(posedge sys_clk) disable iff (rst) // R04
        load_strobe[1:0] != 2'b00 |-> $past(new_req[0]))
        else $error("strobe without request");

    // the reset pulse ends only with the machine back in idle
    chk_fall_idle: assert property (@(posedge sys_clk) disable iff (rst) // R08
        $fell(device_reset) |-> state == DLT_IDLE)
        else $error("reset ended early");

    // a key write suppresses loads in the same word
    chk_key_no_load: assert property (@(posedge sys_clk) disable iff (rst) // R06
        key_hit |=> load_strobe == '0)
        else $error("load beside reset");

    // a taken request shows on pending two cycles later
    chk_pending_rise: assert property (@(posedge sys_clk) disable iff (rst) // R02
        (new_req[0] && !key_hit && state != DLT_SRST) |=> ##1 pending[0])
        else $error("pending not raised");

    // nothing busy means nothing pending next cycle
    chk_idle_pending: assert property (@(posedge sys_clk) disable iff (rst) // R05
        pair_busy == '0 |=> pending == '0)
        else $error("stale pending");

    // a key write drops every busy pair at once
    chk_key_busy_clear: assert property (@(posedge sys_clk) disable iff (rst) // R07
        key_hit |=> pair_busy == '0)
        else $error("busy survived key");

    // the top pair is decoded like the bottom one
    chk_top_pair: assert property (@(posedge sys_clk) disable iff (rst) // R02
        (new_req[PAIRS-1] && !key_hit && state != DLT_SRST) |=> pair_busy[PAIRS-1])
        else $error("top request lost");
endmodule

// >>> dlt_active_model.sv
// Purpose: active register stand-in for the command register
// Assumes: one done pulse per strobed channel
// Notes: slow mode answers two cycles later than prompt mode
`timescale 1ns/1ps
module dlt_active_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [15:0] load_strobe,
    output logic [15:0] load_done
);
    logic [15:0] s1, s2;
    // done is a pulse, never a held level, so a stuck pending shows up
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            {s1, s2, load_done} <= '0;
        else
            {load_done, s2, s1} <= {slow ? s2 : load_strobe, s1, load_strobe};
    end
endmodule

// >>> dlt_cmd_reg_test.sv
// Purpose: bench for the load and reset command register
// Assumes: far side is dlt_active_model
// Notes: reads give zero, so checks watch strobes and pulses
`timescale 1ns/1ps
module dlt_cmd_reg_test;
    import dlt_pkg::*;
    logic sys_clk = 0, rst = 1, slow = 1, rvalid, device_reset;
    logic [15:0] sync_mode = 16'h0002, load_done, rdata, load_strobe;
    logic [7:0] pending;
    dlt_req_t req = '0;
    int n_errors = 0, checks = 0, n;
    dlt_cmd_reg DUT (
        .sys_clk(sys_clk),
        .rst(rst),
        .req(req),
        .sync_mode(sync_mode),
        .load_done(load_done),
        .rdata(rdata),
        .rvalid(rvalid),
        .load_strobe(load_strobe),
        .pending(pending),
        .device_reset(device_reset)
    );
    dlt_active_model partner (
        .sys_clk(sys_clk),
        .rst(rst),
        .slow(slow),
        .load_strobe(load_strobe),
        .load_done(load_done)
    );
    // 25 ns period
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [24:0] seen, input logic [24:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, want);
        end
    endtask
    // one access, request held for exactly one taking edge
    task automatic acc(input logic w, input logic [15:0] d, input logic [4:0] a = 5'h05);
        @(posedge sys_clk) req <= {w, ~w, a, d};
        @(posedge sys_clk) req <= '0;
        #1;
    endtask
    // bounded wait until loads and the reset pulse are over
    task automatic settle;
        for (n = 0; (pending !== 8'h00 || device_reset !== 1'b0) && n < 40; n++)
            @(posedge sys_clk) #1;
        chk(n < 40, 1);
        if (n == 40) final_report();
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 0;
        acc(0, 0);
        chk({rvalid, rdata}, 25'h10000);
        acc(1, 16'h0100);
        chk(load_strobe, 16'h0002);
        // pending lags the busy bit by a cycle
        @(posedge sys_clk) #1;
        chk(pending, 8'h01);
        settle();
        acc(1, 16'h000B);
        chk({load_strobe, pending, device_reset}, 0);
        acc(1, 16'h0000, 5'h06);
        chk(load_strobe, 0);
        $display("test load_basics over");
        @(posedge sys_clk) {slow, sync_mode} <= {1'b0, 16'hFFFF};
        for (int k = 0; k < DLT_PAIRS; k++) begin
            acc(1, 16'h0100 << k);
            chk(load_strobe, 16'h0003 << (2 * k));
        end
        acc(1, 16'hFF0A);
        chk({load_strobe, device_reset}, 1);
        settle();
        chk(n, DLT_RST_PULSE);
        chk(pending, 0);
        acc(0, 0);
        chk(rdata, DLT_CMD_RESET);
        $display("test pairs_and_reset over");
        final_report();
    end
endmodule
